// ---- core/cps_alu.sv ----
// Purpose: Byte arithmetic for rotates, subtraction and store flag update.
// Assumes: Purely combinational; the core registers the outputs.
// Notes:   Only the flags each operation names are changed.
`timescale 1ns/1ps
module cps_alu
(
  input  wire cps_pkg::cps_alu_op_t op,        // Operation select.
  input  wire logic [7:0]           opa,       // Accumulator or memory operand.
  input  wire logic [7:0]           opb,       // Subtrahend.
  input  wire logic                 use_c,     // Include carry as borrow.
  input  wire cps_pkg::cps_flags_t  flags_in,  // Flags before the operation.
  output logic [7:0]                result,    // Result byte.
  output cps_pkg::cps_flags_t       flags_out  // Flags after the operation.
);

  logic [8:0] diff;

  always_comb
  begin
    flags_out = flags_in;
    result    = opa;
    diff      = {1'b0, opa} - {1'b0, opb} - {8'h00, use_c & flags_in.c};
    unique case (op)
      cps_pkg::ALU_ROL:
      begin
        result      = {opa[6:0], flags_in.c};
        flags_out.c = opa[7];
      end
      cps_pkg::ALU_ROR:
      begin
        result      = {flags_in.c, opa[7:1]};
        flags_out.c = opa[0];
      end
      cps_pkg::ALU_SUB:
      begin
        result      = diff[7:0];
        flags_out.c = diff[8];
        flags_out.v = (opa[7] & ~opb[7] & ~diff[7]) | (~opa[7] & opb[7] & diff[7]);
      end
      cps_pkg::ALU_PASS:
      begin
        result      = opa;
        flags_out.v = 1'b0;
      end
    endcase
    flags_out.n = result[7];
    flags_out.z = (result == 8'h00);
    if (op == cps_pkg::ALU_ROL || op == cps_pkg::ALU_ROR)
    begin
      flags_out.v = flags_out.n ^ flags_out.c;
    end
  end

endmodule

// ---- core/cps_core.sv ----
// Purpose: Executes the pop, rotate, return, subtract, set-flag, sleep and store opcodes.
// Assumes: Memory read data is valid in the same cycle as the read request.
// Notes:   Registers are loaded over APB while the core is stopped.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cps_map.svh"
module cps_core
#(
  parameter logic [15:0] IRQ_VEC = `CPS_VEC_IRQ,  // Maskable vector address.
  parameter logic [15:0] NMI_VEC = `CPS_VEC_NMI   // Non-maskable vector address.
)
(
  input  wire logic                clk,        // Clock, 100 MHz.
  input  wire logic                srst,       // Synchronous reset, active high.
  input  wire logic                psel,       // APB select.
  input  wire logic                penable,    // APB enable.
  input  wire logic                pwrite,     // APB write.
  input  wire logic [7:0]          paddr,      // APB byte address.
  input  wire logic [31:0]         pwdata,     // APB write data.
  output logic [31:0]              prdata,     // APB read data.
  output logic                     pready,     // APB ready.
  output logic                     pslverr,    // APB error on unmapped address.
  output cps_pkg::cps_mem_req_t    mem_req,    // System bus request.
  input  wire logic [7:0]          mem_rdata,  // System bus read data.
  input  wire logic                irq,        // Maskable request, level.
  input  wire logic                nmi,        // Non-maskable request, rising edge.
  output logic                     sleeping    // High while asleep.
);

  // ------------------------------------------------------------------
  // Opcode classes
  // ------------------------------------------------------------------
  function automatic logic f_rotm(input logic [7:0] o);
    f_rotm = (o == `CPS_OP_ROLE) || (o == `CPS_OP_ROLX) ||
             (o == `CPS_OP_RORE) || (o == `CPS_OP_RORX);
  endfunction

  function automatic logic f_sbc(input logic [7:0] o);
    f_sbc = o[7] && (o[3:0] == `CPS_OP_SBC_LO);
  endfunction

  function automatic logic f_sta(input logic [7:0] o);
    f_sta = o[7] && (o[3:0] == `CPS_OP_STA_LO) && (o[5:4] != 2'b00);
  endfunction

  function automatic logic f_ext(input logic [7:0] o);
    f_ext = o[7] ? (o[5:4] == 2'b11) : o[4];
  endfunction

  function automatic logic f_idx(input logic [7:0] o);
    f_idx = o[7] ? (o[5:4] == 2'b10) : ~o[4];
  endfunction

  function automatic logic [3:0] f_cycles(input logic [7:0] o);
    f_cycles = 4'h1;
    if (o == `CPS_OP_POPX)       f_cycles = `CPS_CYC_POPX;
    else if (o == `CPS_OP_RETI)  f_cycles = `CPS_CYC_RETI;
    else if (o == `CPS_OP_RETS)  f_cycles = `CPS_CYC_RETS;
    else if (o == `CPS_OP_SLEEP) f_cycles = `CPS_CYC_SLEEP;
    else if (f_rotm(o))          f_cycles = `CPS_CYC_ROTM;
    else if (f_sbc(o) || f_sta(o))
    begin
      unique case (o[5:4])
        2'b00: f_cycles = `CPS_CYC_IMM;
        2'b01: f_cycles = `CPS_CYC_DIR;
        2'b10: f_cycles = `CPS_CYC_IDX;
        2'b11: f_cycles = `CPS_CYC_EXT;
      endcase
    end
  endfunction

  function automatic logic f_known(input logic [7:0] o);
    f_known = (f_cycles(o) != 4'h1) ||
              (o == `CPS_OP_ROLA) || (o == `CPS_OP_ROLB) || (o == `CPS_OP_RORA) ||
              (o == `CPS_OP_RORB) || (o == `CPS_OP_SUBBA) || (o == `CPS_OP_SETC) ||
              (o == `CPS_OP_SETI) || (o == `CPS_OP_SETV);
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  cps_pkg::cps_state_t state;
  cps_pkg::cps_flags_t flags;
  cps_pkg::cps_flags_t alu_flags;
  cps_pkg::cps_alu_op_t alu_op;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [15:0] index_reg;
  logic [15:0] stack_pointer;
  logic [15:0] prog_counter;
  logic [15:0] ea;
  logic [7:0]  opcode;
  logic [7:0]  opnd;
  logic [3:0]  step;
  logic        vec_nmi;
  logic        run;
  logic        illegal;
  logic        irq_s1, irq_s2, nmi_s1, nmi_s2, nmi_s3;
  logic        nmi_pend;
  logic        take_int;
  logic        nmi_taken;
  logic        wake;
  logic [7:0]  dec;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic        alu_c;
  logic [7:0]  alu_res;
  logic        memop;
  logic        is_stack;
  logic [3:0]  npops;
  logic [3:0]  acc_stp;
  logic [3:0]  last;
  logic        op_fetch;
  logic [7:0]  sel_acc;
  logic        apb_we;
  logic        mapped;
  logic [31:0] rd_mux;

  // ------------------------------------------------------------------
  // Request synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {irq_s1, irq_s2, nmi_s1, nmi_s2, nmi_s3} <= 5'h00;
    end
    else
    begin
      irq_s1 <= irq;
      irq_s2 <= irq_s1;
      nmi_s1 <= nmi;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      nmi_pend <= 1'b0;
    else
      nmi_pend <= (nmi_s2 & ~nmi_s3) | (nmi_pend & ~nmi_taken);
  end

  assign take_int  = nmi_pend | (irq_s2 & ~flags.i);
  assign wake      = nmi_pend | irq_s2;
  assign nmi_taken = nmi_pend & (((state == cps_pkg::ST_FETCH) & run) |
                                 (state == cps_pkg::ST_SLEEP));
  assign sleeping  = (state == cps_pkg::ST_SLEEP);

  // ------------------------------------------------------------------
  // Decode and bus request
  // ------------------------------------------------------------------
  always_comb
  begin
    memop    = f_rotm(opcode) | f_sbc(opcode) | f_sta(opcode);
    is_stack = (opcode == `CPS_OP_POPX) | (opcode == `CPS_OP_RETS) | (opcode == `CPS_OP_RETI);
    npops    = (opcode == `CPS_OP_RETI) ? 4'h7 : 4'h2;
    acc_stp  = (opcode[7] && opcode[5:4] == 2'b00) ? 4'h1 :
               (opcode[7] && opcode[5:4] == 2'b01) ? 4'h2 : 4'h3;
    last     = f_cycles(opcode) - 4'h1;
    op_fetch = memop && ((step == 4'h1) || (step == 4'h2 && f_ext(opcode)));
    sel_acc  = opcode[6] ? acc_b : acc_a;
    mem_req  = '0;
    unique case (state)
      cps_pkg::ST_FETCH:
      begin
        mem_req.addr = prog_counter;
        mem_req.rd   = run & ~take_int;
      end
      cps_pkg::ST_EXEC:
      begin
        if (is_stack && step <= npops)
        begin
          mem_req.addr = stack_pointer + 16'h0001;
          mem_req.rd   = 1'b1;
        end
        else if (op_fetch)
        begin
          mem_req.addr = prog_counter;
          mem_req.rd   = 1'b1;
        end
        else if (memop && step == acc_stp)
        begin
          mem_req.addr  = ea;
          mem_req.rd    = ~f_sta(opcode);
          mem_req.wr    = f_sta(opcode);
          mem_req.wdata = sel_acc;
        end
        else if (f_rotm(opcode) && step == 4'h5)
        begin
          mem_req.addr  = ea;
          mem_req.wr    = 1'b1;
          mem_req.wdata = alu_res;
        end
      end
      cps_pkg::ST_VEC:
      begin
        mem_req.addr = (vec_nmi ? NMI_VEC : IRQ_VEC) + {15'h0000, step[0]};
        mem_req.rd   = 1'b1;
      end
      default:
      begin
        mem_req = '0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Arithmetic operand select
  // ------------------------------------------------------------------
  always_comb
  begin
    dec    = (state == cps_pkg::ST_FETCH) ? mem_rdata : opcode;
    alu_op = cps_pkg::ALU_PASS;
    alu_a  = acc_a;
    alu_b  = acc_b;
    alu_c  = 1'b0;
    if (dec == `CPS_OP_ROLA || dec == `CPS_OP_ROLB)
    begin
      alu_op = cps_pkg::ALU_ROL;
      alu_a  = dec[4] ? acc_b : acc_a;
    end
    else if (dec == `CPS_OP_RORA || dec == `CPS_OP_RORB)
    begin
      alu_op = cps_pkg::ALU_ROR;
      alu_a  = dec[4] ? acc_b : acc_a;
    end
    else if (dec == `CPS_OP_SUBBA)
    begin
      alu_op = cps_pkg::ALU_SUB;
    end
    else if (f_rotm(dec))
    begin
      alu_op = (dec[3:0] == 4'h9) ? cps_pkg::ALU_ROL : cps_pkg::ALU_ROR;
      alu_a  = opnd;
    end
    else if (f_sbc(dec))
    begin
      alu_op = cps_pkg::ALU_SUB;
      alu_a  = dec[6] ? acc_b : acc_a;
      alu_b  = mem_rdata;
      alu_c  = 1'b1;
    end
    else
    begin
      alu_a  = dec[6] ? acc_b : acc_a;
    end
  end

  cps_alu u_alu
  (
    .op        (alu_op),
    .opa       (alu_a),
    .opb       (alu_b),
    .use_c     (alu_c),
    .flags_in  (flags),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  // ------------------------------------------------------------------
  // CPU registers and sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state         <= cps_pkg::ST_IDLE;
      flags         <= `CPS_RST_FLAGS;
      acc_a         <= 8'h00;
      acc_b         <= 8'h00;
      index_reg     <= 16'h0000;
      stack_pointer <= `CPS_RST_SP;
      prog_counter  <= `CPS_RST_PC;
      ea            <= 16'h0000;
      opcode        <= 8'h00;
      opnd          <= 8'h00;
      step          <= 4'h0;
      vec_nmi       <= 1'b0;
    end
    else
    begin
      if (apb_we && state == cps_pkg::ST_IDLE)
      begin
        unique case (paddr)
          `CPS_OFF_ACC:   {acc_b, acc_a} <= pwdata[15:0];
          `CPS_OFF_INDEX: index_reg <= pwdata[15:0];
          `CPS_OFF_SP:    stack_pointer <= pwdata[15:0];
          `CPS_OFF_PC:    prog_counter <= pwdata[15:0];
          `CPS_OFF_FLAGS: flags <= {2'b00, pwdata[5:0]};
          default:        ;
        endcase
      end
      unique case (state)
        cps_pkg::ST_IDLE:
        begin
          if (run)
            state <= cps_pkg::ST_FETCH;
        end
        cps_pkg::ST_FETCH:
        begin
          if (!run)
            state <= cps_pkg::ST_IDLE;
          else if (take_int)
          begin
            vec_nmi <= nmi_pend;
            flags.i <= 1'b1;
            step    <= 4'h0;
            state   <= cps_pkg::ST_VEC;
          end
          else
          begin
            prog_counter <= prog_counter + 16'h0001;
            unique case (mem_rdata)
              `CPS_OP_ROLA, `CPS_OP_RORA, `CPS_OP_SUBBA:
              begin
                acc_a <= alu_res;
                flags <= alu_flags;
              end
              `CPS_OP_ROLB, `CPS_OP_RORB:
              begin
                acc_b <= alu_res;
                flags <= alu_flags;
              end
              `CPS_OP_SETC: flags.c <= 1'b1;
              `CPS_OP_SETI: flags.i <= 1'b1;
              `CPS_OP_SETV: flags.v <= 1'b1;
              default:
              begin
                if (f_cycles(mem_rdata) != 4'h1)
                begin
                  opcode <= mem_rdata;
                  step   <= 4'h1;
                  state  <= cps_pkg::ST_EXEC;
                end
              end
            endcase
          end
        end
        cps_pkg::ST_EXEC:
        begin
          if (is_stack && step <= npops)
          begin
            stack_pointer <= stack_pointer + 16'h0001;
            if (opcode == `CPS_OP_POPX)
            begin
              if (step == 4'h1) index_reg[15:8] <= mem_rdata;
              else              index_reg[7:0]  <= mem_rdata;
            end
            else if (opcode == `CPS_OP_RETS)
            begin
              if (step == 4'h1) prog_counter[15:8] <= mem_rdata;
              else              prog_counter[7:0]  <= mem_rdata;
            end
            else
            begin
              unique case (step)
                4'h1:    flags <= {2'b00, mem_rdata[5:0]};
                4'h2:    acc_b <= mem_rdata;
                4'h3:    acc_a <= mem_rdata;
                4'h4:    index_reg[15:8] <= mem_rdata;
                4'h5:    index_reg[7:0] <= mem_rdata;
                4'h6:    prog_counter[15:8] <= mem_rdata;
                default: prog_counter[7:0] <= mem_rdata;
              endcase
            end
          end
          if (op_fetch)
          begin
            prog_counter <= prog_counter + 16'h0001;
            if (step == 4'h2)
              ea[7:0] <= mem_rdata;
            else if (f_ext(opcode))
              ea[15:8] <= mem_rdata;
            else if (f_idx(opcode))
              ea <= index_reg + {8'h00, mem_rdata};
            else
              ea <= {8'h00, mem_rdata};
          end
          if (memop && step == acc_stp)
          begin
            if (f_sbc(opcode))
            begin
              if (opcode[6]) acc_b <= alu_res;
              else           acc_a <= alu_res;
              flags <= alu_flags;
            end
            else if (f_sta(opcode))
              flags <= alu_flags;
            else
              opnd <= mem_rdata;
          end
          if (f_rotm(opcode) && step == 4'h5)
            flags <= alu_flags;
          if (step == last)
            state <= (opcode == `CPS_OP_SLEEP) ? cps_pkg::ST_SLEEP : cps_pkg::ST_FETCH;
          else
            step <= step + 4'h1;
        end
        cps_pkg::ST_SLEEP:
        begin
          if (wake)
          begin
            if (take_int)
            begin
              vec_nmi <= nmi_pend;
              flags.i <= 1'b1;
              step    <= 4'h0;
              state   <= cps_pkg::ST_VEC;
            end
            else
              state <= cps_pkg::ST_FETCH;
          end
        end
        cps_pkg::ST_VEC:
        begin
          step <= step + 4'h1;
          if (step == 4'h0)
            prog_counter[15:8] <= mem_rdata;
          else
          begin
            prog_counter[7:0] <= mem_rdata;
            state             <= cps_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign pready = 1'b1;
  assign mapped = (paddr <= `CPS_OFF_STATUS) && (paddr[1:0] == 2'b00);
  assign apb_we = psel & penable & pwrite & mapped;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `CPS_OFF_CTRL:   rd_mux = {31'h0000_0000, run};
      `CPS_OFF_ACC:    rd_mux = {16'h0000, acc_b, acc_a};
      `CPS_OFF_INDEX:  rd_mux = {16'h0000, index_reg};
      `CPS_OFF_SP:     rd_mux = {16'h0000, stack_pointer};
      `CPS_OFF_PC:     rd_mux = {16'h0000, prog_counter};
      `CPS_OFF_FLAGS:  rd_mux = {24'h00_0000, flags};
      `CPS_OFF_STATUS: rd_mux = {29'h0000_0000, illegal, state != cps_pkg::ST_IDLE, sleeping};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      run <= 1'b0;
    else if (apb_we && paddr == `CPS_OFF_CTRL)
      run <= pwdata[`CPS_CTRL_RUN];
  end

  // Unknown opcodes run as one-cycle no-ops and leave this sticky mark.
  always_ff @(posedge clk)
  begin
    if (srst)
      illegal <= 1'b0;
    else if (state == cps_pkg::ST_FETCH && mem_req.rd && !f_known(mem_rdata))
      illegal <= 1'b1;
    else if (apb_we && paddr == `CPS_OFF_STATUS && pwdata[`CPS_STAT_ILL])
      illegal <= 1'b0;
  end

endmodule

// ---- core/cps_map.svh ----
// Purpose: Offsets, field positions, reset values, opcodes and cycle counts of the CPU slice.
// Assumes: Included by its bare name by the core.
// Notes:   Definitions only.
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

`define CPS_OFF_CTRL    8'h00
`define CPS_OFF_ACC     8'h04
`define CPS_OFF_INDEX   8'h08
`define CPS_OFF_SP      8'h0C
`define CPS_OFF_PC      8'h10
`define CPS_OFF_FLAGS   8'h14
`define CPS_OFF_STATUS  8'h18

`define CPS_CTRL_RUN    0
`define CPS_STAT_SLEEP  0
`define CPS_STAT_BUSY   1
`define CPS_STAT_ILL    2

`define CPS_RST_SP      16'h00FF
`define CPS_RST_PC      16'h0000
`define CPS_RST_FLAGS   8'h10
`define CPS_VEC_IRQ     16'hFFF8
`define CPS_VEC_NMI     16'hFFFC

`define CPS_OP_POPX     8'h38
`define CPS_OP_RETI     8'h3B
`define CPS_OP_RETS     8'h39
`define CPS_OP_SUBBA    8'h10
`define CPS_OP_SETC     8'h0D
`define CPS_OP_SETI     8'h0F
`define CPS_OP_SETV     8'h0B
`define CPS_OP_SLEEP    8'h1A
`define CPS_OP_ROLA     8'h49
`define CPS_OP_ROLB     8'h59
`define CPS_OP_ROLE     8'h79
`define CPS_OP_ROLX     8'h69
`define CPS_OP_RORA     8'h46
`define CPS_OP_RORB     8'h56
`define CPS_OP_RORE     8'h76
`define CPS_OP_RORX     8'h66
`define CPS_OP_SBC_LO   4'h2
`define CPS_OP_STA_LO   4'h7

`define CPS_CYC_POPX    4'h4
`define CPS_CYC_RETI    4'hA
`define CPS_CYC_RETS    4'h5
`define CPS_CYC_SLEEP   4'h4
`define CPS_CYC_ROTM    4'h6
`define CPS_CYC_IMM     4'h2
`define CPS_CYC_DIR     4'h3
`define CPS_CYC_EXT     4'h4
`define CPS_CYC_IDX     4'h4

`endif

// ---- core/cps_pkg.sv ----
// Purpose: Types shared by the CPU slice core and its arithmetic unit.
// Assumes: Encodings are written out here; cps_map.svh is not included.
// Notes:   Flag layout follows the processor flag byte.
package cps_pkg;

  typedef struct packed {
    logic [1:0] spare;
    logic       h;
    logic       i;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
  } cps_flags_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_EXEC  = 5'b00100,
    ST_SLEEP = 5'b01000,
    ST_VEC   = 5'b10000
  } cps_state_t;

  typedef enum logic [3:0] {
    ALU_ROL  = 4'b0001,
    ALU_ROR  = 4'b0010,
    ALU_SUB  = 4'b0100,
    ALU_PASS = 4'b1000
  } cps_alu_op_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } cps_mem_req_t;

endpackage

// ---- sim/cps_core_chk.sv ----
// Purpose: Port checks of the CPU slice.
// Assumes: Bound into cps_core.
// Notes:   Core outputs are judged, plus the opcode byte read before sleep.
`timescale 1ns/1ps
module cps_core_chk
#(
  parameter logic [15:0] IRQ_VEC = 16'hFFF8  // Maskable vector.
)
(
  input logic                  clk,        // Clock.
  input logic                  srst,       // Reset.
  input logic                  psel,       // Select.
  input logic                  penable,    // Enable.
  input logic [7:0]            paddr,      // Address.
  input logic                  pready,     // Ready.
  input logic                  pslverr,    // Error.
  input cps_pkg::cps_mem_req_t mem_req,    // Bus request.
  input logic [7:0]            mem_rdata,  // Bus data.
  input logic                  irq,        // Request.
  input logic                  nmi,        // Urgent request.
  input logic                  sleeping    // Asleep.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; psel && !penable && paddr > 8'h18 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped address");
  property p_excl; !(mem_req.rd && mem_req.wr); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_quiet; sleeping |-> !mem_req.rd && !mem_req.wr; endproperty
  a_quiet: assert property (p_quiet) else $error("bus used asleep");
  property p_entry;
    $rose(sleeping) |-> $past(mem_req.rd, 4) && $past(mem_rdata, 4) == 8'h1A && !$past(mem_req.rd);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entry timing");
  property p_popx;
    mem_req.rd && mem_rdata == 8'h38 |=> mem_req.rd ##1 mem_req.rd ##1 !mem_req.rd ##1 mem_req.rd;
  endproperty
  a_popx: assert property (p_popx) else $error("pop index timing");
  property p_stay; (sleeping && !irq && !nmi) [*8] |=> sleeping; endproperty
  a_stay: assert property (p_stay) else $error("woke without request");
  property p_wake; $fell(sleeping) |-> mem_req.rd; endproperty
  a_wake: assert property (p_wake) else $error("no read on wake");
  property p_vec;
    mem_req.rd && mem_req.addr == IRQ_VEC |=> mem_req.rd && mem_req.addr == IRQ_VEC + 16'h0001;
  endproperty
  a_vec: assert property (p_vec) else $error("vector low byte missed");
  c_wake: cover property ($fell(sleeping));
  c_vec: cover property (mem_req.rd && mem_req.addr == IRQ_VEC);
  c_wr: cover property (mem_req.wr);
endmodule

bind cps_core cps_core_chk #(.IRQ_VEC(IRQ_VEC)) u_chk (.*);

// ---- sim/cps_mem_model.sv ----
// Purpose: Memory on the far side of the system bus.
// Assumes: Reads answer in the same cycle.
// Notes:   Idle data is the inverse of the last byte read.
`timescale 1ns/1ps
module cps_mem_model
(
  input  wire logic                  clk,       // Clock.
  input  wire cps_pkg::cps_mem_req_t mem_req,   // Request.
  output logic [7:0]                 mem_rdata  // Data.
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last;
  always @(posedge clk)
  begin
    if (mem_req.rd)
      last <= mem_rdata;
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule

// ---- sim/tb_cpu_instr_subset_pul_to_store.sv ----
// Purpose: Runs short programs through the CPU slice.
// Assumes: Each program ends asleep so registers can be read.
// Notes:   Both interrupt requests are driven by the initial block.
`timescale 1ns/1ps
module tb_cpu_instr_subset_pul_to_store;
  logic                  clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic                  pwrite = 1'b0, irq = 1'b0, nmi = 1'b0, pready, pslverr, sleeping;
  logic [7:0]            paddr = 8'h00, mem_rdata;
  logic [31:0]           pwdata = 32'h0000_0000, prdata;
  cps_pkg::cps_mem_req_t mem_req;
  int                    failures = 0, check_count = 0;
  always #5 clk = ~clk;
  cps_core dut (.*);
  cps_mem_model u_mem (.*);
  task automatic close_out;
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 16 && pready !== 1'b1; n++)
      @(posedge clk);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    if (n == 16)
      close_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, prdata);
    chk("pslverr", {31'h0, a > 8'h18}, {31'h0, pslverr});
  endtask
  task automatic ws(input logic lvl);
    int n;
    for (n = 0; n < 300 && sleeping !== lvl; n++)
      @(posedge clk);
    chk("sleeping", {31'h0, lvl}, {31'h0, sleeping});
    if (sleeping !== lvl)
      close_out;
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] q[$]);
    foreach (q[i])
      u_mem.mem[a + 16'(i)] = q[i];
  endtask
  initial
  begin
    put(16'h0000, '{8'h38, 8'h0D, 8'h49, 8'h10, 8'h97, 8'h10, 8'h0B, 8'h1A, 8'h39});
    put(16'h0100, '{8'h12, 8'h34, 8'h00, 8'h40, 8'h05, 8'h11, 8'h22, 8'h56, 8'h78, 8'h00, 8'h60});
    put(16'h0040, '{8'h3B});
    put(16'h0060, '{8'h82, 8'h05, 8'h56, 8'h1A, 8'h1A});
    put(16'h0080, '{8'h1A});
    put(16'hFFF8, '{8'h00, 8'h80});
    put(16'h0090, '{8'hD2, 8'h20, 8'hB2, 8'h00, 8'h21, 8'hE2, 8'h08, 8'h79, 8'h00, 8'h22,
                    8'h66, 8'h09, 8'hF7, 8'h00, 8'h23, 8'hA7, 8'h0B, 8'h01, 8'h1A});
    put(16'h0020, '{8'h03, 8'h1C, 8'h40});
    put(16'h5680, '{8'h05, 8'h03});
    put(16'hFFFC, '{8'h00, 8'h90});
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, 8'h04, 32'h0000_0181);
    apb(1'b1, 8'h00, 32'h0000_0001);
    ws(1'b1);
    rd(8'h04, 32'h0000_0102);
    rd(8'h08, 32'h0000_1234);
    rd(8'h0C, 32'h0000_0101);
    rd(8'h14, 32'h0000_0012);
    rd(8'h18, 32'h0000_0003);
    rd(8'h1C, 32'h0000_0000);
    chk("stored byte", 32'h0000_0002, {24'h0, u_mem.mem[16]});
    irq <= 1'b1;
    ws(1'b0);
    irq <= 1'b0;
    ws(1'b1);
    rd(8'h04, 32'h0000_081C);
    rd(8'h08, 32'h0000_5678);
    rd(8'h0C, 32'h0000_010A);
    rd(8'h14, 32'h0000_0003);
    irq <= 1'b1;
    ws(1'b0);
    irq <= 1'b0;
    ws(1'b1);
    rd(8'h14, 32'h0000_0013);
    rd(8'h10, 32'h0000_0081);
    nmi <= 1'b1;
    ws(1'b0);
    nmi <= 1'b0;
    ws(1'b1);
    rd(8'h04, 32'h0000_FF00);
    rd(8'h14, 32'h0000_0015);
    rd(8'h10, 32'h0000_00A3);
    rd(8'h18, 32'h0000_0007);
    apb(1'b1, 8'h18, 32'h0000_0004);
    rd(8'h18, 32'h0000_0003);
    chk("rotated byte", 32'h0000_0081, {24'h0, u_mem.mem[16'h0022]});
    chk("rotated byte", 32'h0000_0001, {24'h0, u_mem.mem[16'h5681]});
    chk("stored byte", 32'h0000_00FF, {24'h0, u_mem.mem[16'h0023]});
    chk("stored byte", 32'h0000_0000, {24'h0, u_mem.mem[16'h5683]});
    close_out;
  end
endmodule
